/* logic/blink_pattern_pkg.sv */
`default_nettype none
package blink_pattern_pkg;

	// Register pointer values for the two control bytes.
	localparam logic [7:0] GROUP_BLINK_PERIOD_ADDR   = 8'h1B;
	localparam logic [7:0] OUTPUT_PATTERN_INDEX_ADDR = 8'h1C;

	// Values after reset.
	localparam logic [7:0] GROUP_BLINK_PERIOD_RST   = 8'h00;
	localparam logic [7:0] OUTPUT_PATTERN_INDEX_RST = 8'h00;
	localparam logic [7:0] POINTER_RST              = 8'h00;
	localparam logic [7:0] UNMAPPED_READ            = 8'h00;

	// Output drive select codes, two bits per channel.
	localparam logic [1:0] DRIVE_OFF   = 2'h0;
	localparam logic [1:0] DRIVE_ON    = 2'h1;
	localparam logic [1:0] DRIVE_INDIV = 2'h2;
	localparam logic [1:0] DRIVE_GROUP = 2'h3;

	// Pattern table landmarks.
	localparam logic [7:0] PATTERN_ALL_ON   = 8'h00;
	localparam logic [7:0] PATTERN_ALL_OFF  = 8'h01;
	localparam logic [7:0] PATTERN_ODD      = 8'h02;
	localparam logic [7:0] PATTERN_EVEN     = 8'h03;
	localparam logic [7:0] PATTERN_THIRD_2  = 8'h04;
	localparam logic [7:0] PATTERN_THIRD_1  = 8'h05;
	localparam logic [7:0] PATTERN_THIRD_0  = 8'h06;
	localparam logic [7:0] PATTERN_WALK_LO  = 8'h07;
	localparam logic [7:0] PATTERN_WALK_HI  = 8'h1B;

	// Blink timing: one period step is 1/24 s, split into 256 duty ticks.
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned BLINK_STEP_HZ  = 24;
	localparam int unsigned DUTY_STEPS     = 256;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / (BLINK_STEP_HZ * DUTY_STEPS);
	localparam int unsigned TICK_W         = 12;
	localparam logic [7:0]  PHASE_LAST_LOW = 8'hFF;

	// Number of phase ticks for which the group blink is on.
	function automatic logic [16:0] blink_on_limit(input logic [7:0] duty, input logic [7:0] code);
		blink_on_limit = 17'(duty) * 17'({1'b0, code} + 9'h001);
	endfunction

endpackage
`default_nettype wire

/* logic/pattern_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module pattern_decode
	import blink_pattern_pkg::*;
#(
	parameter int CHANNELS = 24
) (
	input  wire logic [7:0]          index,
	output logic      [CHANNELS-1:0] enable
);

	// Expands a pattern index into per-channel enables; rows above the walk enable nothing.
	always_comb begin
		enable = '0;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			unique case (1'b1)
				(index == PATTERN_ALL_ON):  enable[ch] = 1'b1;
				(index == PATTERN_ALL_OFF): enable[ch] = 1'b0;
				(index == PATTERN_ODD):     enable[ch] = (ch % 2) == 1;
				(index == PATTERN_EVEN):    enable[ch] = (ch % 2) == 0;
				(index == PATTERN_THIRD_2): enable[ch] = (ch % 3) == 2;
				(index == PATTERN_THIRD_1): enable[ch] = (ch % 3) == 1;
				(index == PATTERN_THIRD_0): enable[ch] = (ch % 3) == 0;
				(index >= PATTERN_WALK_LO && index <= PATTERN_WALK_HI):
					enable[ch] = index == 8'(ch + 7);
				default:                    enable[ch] = 1'b0;
			endcase
		end
	end

endmodule // pattern_decode
`default_nettype wire

/* logic/group_blink_and_pattern_gate.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Byte register at 1Bh holds the blink period code, read and write.
// - In dimming mode the period code has no effect on any LED output.
// - Group blink gates only channels whose drive select is 11.
// - Blink period is (code + 1) / 24 seconds in 256 linear steps.
// - Byte register at 1Ch holds pattern index, resets to zero.
// - Once 1Ch is addressed, each following data byte is a new index.
// - Pattern writes take effect at the data byte acknowledge while ce is high.
// - Output gate pin high forces every LED output off.
// - Output gate pin low lets on only channels the pattern enables.
// - Indices 00-06: all, none, odd, even, thirds from 2, 1, 0.
// - Indices 07-1B enable only channel index minus 7.
// - Mode selector 0 means group dimming, 1 means group blinking.
// - In blinking mode on fraction of each period is duty / 256.
module group_blink_and_pattern_gate
	import blink_pattern_pkg::*;
#(
	parameter int          CHANNELS    = 24,
	parameter int unsigned TICK_LENGTH = TICK_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	input  wire logic                  addr_ack,
	input  wire logic                  data_ack,
	input  wire logic [7:0]            bus_byte,
	output logic      [7:0]            rd_data,
	input  wire logic                  group_mode_selector,
	input  wire logic [7:0]            group_duty_code,
	input  wire logic                  dim_pwm,
	input  wire logic [2*CHANNELS-1:0] output_drive_select,
	input  wire logic [CHANNELS-1:0]   indiv_pwm,
	input  wire logic                  oe_n,
	output logic      [CHANNELS-1:0]   led_on,
	output logic      [7:0]            blink_period_code,
	output logic      [7:0]            pattern_index_field
);

	typedef struct packed {
		logic [7:0]          period;
		logic [7:0]          pattern;
		logic [7:0]          pointer;
		logic [7:0]          code_act;
		logic [TICK_W-1:0]   tick;
		logic [15:0]         phase;
		logic [7:0]          rd_data;
		logic [CHANNELS-1:0] led;
	} state_s;

	state_s              state_r;
	state_s              state_nxt;
	logic [CHANNELS-1:0] pattern_en;
	logic [CHANNELS-1:0] channel_drive;
	logic                group_gate;
	logic                tick_done;
	logic                period_wrap;
	logic [16:0]         on_limit;

	pattern_decode #(
		.CHANNELS (CHANNELS)
	) u_pattern_decode (
		.index    (state_r.pattern),
		.enable   (pattern_en)
	);

	// Tick and period boundary of the blink counter.
	assign tick_done   = state_r.tick == TICK_W'(TICK_LENGTH - 1);
	assign period_wrap = tick_done && state_r.phase == {state_r.code_act, PHASE_LAST_LOW};
	assign on_limit    = blink_on_limit(group_duty_code, state_r.code_act);

	// Group gate follows the blink phase in blinking mode and the dimming source otherwise.
	always_comb begin
		if (group_mode_selector) begin
			group_gate = {1'b0, state_r.phase} < on_limit;
		end else begin
			group_gate = dim_pwm;
		end
	end

	// Per-channel drive before the pattern and output gate.
	always_comb begin
		channel_drive = '0;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			unique case (output_drive_select[2*ch +: 2])
				DRIVE_OFF:   channel_drive[ch] = 1'b0;
				DRIVE_ON:    channel_drive[ch] = 1'b1;
				DRIVE_INDIV: channel_drive[ch] = indiv_pwm[ch];
				DRIVE_GROUP: channel_drive[ch] = indiv_pwm[ch] & group_gate;
			endcase
		end
	end

	// Next state: register writes, blink counter, read mux and gated outputs.
	always_comb begin
		state_nxt = state_r;
		if (addr_ack) begin
			state_nxt.pointer = bus_byte;
		end else if (data_ack) begin
			// The pointer is left as it is, so a run of bytes keeps hitting the same register.
			if (state_r.pointer == GROUP_BLINK_PERIOD_ADDR) begin
				state_nxt.period = bus_byte;
			end
			if (state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR) begin
				state_nxt.pattern = bus_byte;
			end
		end
		if (!group_mode_selector) begin
			state_nxt.tick     = '0;
			state_nxt.phase    = '0;
			state_nxt.code_act = state_r.period;
		end else if (tick_done) begin
			state_nxt.tick = '0;
			if (period_wrap) begin
				state_nxt.phase    = '0;
				state_nxt.code_act = state_r.period;
			end else begin
				state_nxt.phase = state_r.phase + 16'h0001;
			end
		end else begin
			state_nxt.tick = state_r.tick + TICK_W'(1);
		end
		unique case (state_r.pointer)
			GROUP_BLINK_PERIOD_ADDR:   state_nxt.rd_data = state_r.period;
			OUTPUT_PATTERN_INDEX_ADDR: state_nxt.rd_data = state_r.pattern;
			default:                   state_nxt.rd_data = UNMAPPED_READ;
		endcase
		if (oe_n) begin
			state_nxt.led = '0;
		end else begin
			state_nxt.led = channel_drive & pattern_en;
		end
	end

	// State register with synchronous reset and clock enable.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_r.period   <= GROUP_BLINK_PERIOD_RST;
			state_r.pattern  <= OUTPUT_PATTERN_INDEX_RST;
			state_r.pointer  <= POINTER_RST;
			state_r.code_act <= GROUP_BLINK_PERIOD_RST;
			state_r.tick     <= '0;
			state_r.phase    <= '0;
			state_r.rd_data  <= UNMAPPED_READ;
			state_r.led      <= '0;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register.
	assign rd_data             = state_r.rd_data;
	assign led_on              = state_r.led;
	assign blink_period_code   = state_r.period;
	assign pattern_index_field = state_r.pattern;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Checks on gating, register writes and read back.
	oe_forces_off_a: assert property (ce && oe_n |=> led_on == '0)
		else $error("LED on while output gate high");
	pattern_gate_a: assert property (ce && !oe_n |=> (led_on & ~$past(pattern_en)) == '0)
		else $error("LED on outside selected pattern");
	pattern_write_a: assert property (
		ce && data_ack && !addr_ack && state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR
		|=> pattern_index_field == $past(bus_byte))
		else $error("Pattern write not taken at acknowledge");
	pointer_hold_a: assert property (ce && data_ack && !addr_ack |=> $stable(state_r.pointer))
		else $error("Pointer moved on data byte");
	addr_wins_a: assert property (
		ce && addr_ack |=> state_r.pointer == $past(bus_byte)
		&& $stable(pattern_index_field) && $stable(blink_period_code))
		else $error("Pointer byte taken as data");
	period_write_a: assert property (
		ce && data_ack && !addr_ack && state_r.pointer == GROUP_BLINK_PERIOD_ADDR
		|=> blink_period_code == $past(bus_byte))
		else $error("Period write lost");
	period_read_a: assert property (
		ce && state_r.pointer == GROUP_BLINK_PERIOD_ADDR |=> rd_data == $past(blink_period_code))
		else $error("Period read back wrong");
	pattern_read_a: assert property (
		ce && state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR |=> rd_data == $past(pattern_index_field))
		else $error("Pattern read back wrong");
	// A low clock enable must hold every register, counters included.
	ce_freeze_a: assert property (!ce |=> $stable(state_r))
		else $error("State moved with clock enable low");

	// Checks on the group gate in both modes.
	dim_ignores_code_a: assert property (
		ce && !group_mode_selector && !oe_n && output_drive_select[1:0] == DRIVE_GROUP
		|=> led_on[0] == $past(indiv_pwm[0] & dim_pwm & pattern_en[0]))
		else $error("Period code leaks into dimming");
	dim_hold_a: assert property (
		ce && !group_mode_selector |=> state_r.phase == '0 && state_r.code_act == $past(state_r.period))
		else $error("Blink counter runs in dimming");
	indiv_unblinked_a: assert property (
		ce && !oe_n && output_drive_select[1:0] == DRIVE_INDIV
		|=> led_on[0] == $past(indiv_pwm[0] & pattern_en[0]))
		else $error("Blink touched non-group channel");
	// The active code may move while blinking only on the edge that closes a period.
	code_at_wrap_a: assert property (
		$past(resetn) && $past(group_mode_selector) && $changed(state_r.code_act)
		|-> $past(period_wrap && ce))
		else $error("Period code applied mid period");
	blink_duty_a: assert property (
		group_mode_selector && state_r.phase == '0 |-> group_gate == (group_duty_code != 8'h00))
		else $error("Blink on time wrong");
	// Even the largest duty leaves the last tick of a period dark.
	blink_end_off_a: assert property (
		group_mode_selector && state_r.phase == {state_r.code_act, PHASE_LAST_LOW} |-> !group_gate)
		else $error("Blink still on at period end");
	phase_bound_a: assert property (
		group_mode_selector && ce
		|=> state_r.phase <= {state_r.code_act, PHASE_LAST_LOW} || !group_mode_selector)
		else $error("Blink phase past period end");

	// Checks on the pattern decode.
	walk_decode_a: assert property (
		state_r.pattern >= PATTERN_WALK_LO && state_r.pattern <= PATTERN_WALK_HI
		|-> pattern_en == (CHANNELS'(1) << (state_r.pattern - PATTERN_WALK_LO)))
		else $error("Walk pattern decode wrong");
	all_on_decode_a: assert property (state_r.pattern == PATTERN_ALL_ON |-> &pattern_en)
		else $error("All-on pattern decode wrong");
	all_off_decode_a: assert property (state_r.pattern == PATTERN_ALL_OFF |-> pattern_en == '0)
		else $error("All-off pattern decode wrong");

	// Main scenarios: period wrap, walk step, gate release, dimmed group channel and a run of indices.
	blink_wrap_c: cover property (group_mode_selector && ce && period_wrap);
	walk_step_c: cover property (ce && data_ack && state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR
		&& bus_byte == PATTERN_WALK_LO);
	oe_release_c: cover property (ce && $fell(oe_n) && led_on == '0 ##1 led_on != '0);
	dim_group_c: cover property (ce && !group_mode_selector && !oe_n && output_drive_select[1:0] == DRIVE_GROUP
		&& dim_pwm);
	index_run_c: cover property (ce && data_ack && state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR
		##1 ce && data_ack && state_r.pointer == OUTPUT_PATTERN_INDEX_ADDR);

endmodule // group_blink_and_pattern_gate
`default_nettype wire

/* testbench/bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus controller: one acknowledge strobe per cycle, changed at the falling edge.
module bus_ctrl_model (
	input  wire logic       mclk,
	output logic            addr_ack,
	output logic            data_ack,
	output logic      [7:0] bus_byte
);
	initial begin
		addr_ack = 1'b0;
		data_ack = 1'b0;
		bus_byte = 8'h00;
	end
	// Idle cycles invert the byte so a stale value never looks valid.
	task automatic strobe(input logic a, input logic d, input logic [7:0] b);
		@(negedge mclk);
		addr_ack = a;
		data_ack = d;
		bus_byte = (a | d) ? b : ~bus_byte;
	endtask
endmodule // bus_ctrl_model
`default_nettype wire

/* testbench/tb_group_blink_and_pattern_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_group_blink_and_pattern_gate;
	import blink_pattern_pkg::*;
	localparam int TL = 2;
	logic        mclk = 1'b0, resetn = 1'b0, gms = 1'b0, dim = 1'b0, oe_n = 1'b1, ce = 1'b1, prev;
	logic        addr_ack, data_ack;
	logic [7:0]  bus_byte, rd_data, bpc, pif, per, duty = 8'h00;
	logic [47:0] drv = {24{DRIVE_ON}};
	logic [23:0] pw = '0, led_on, e;
	int          fail_count = 0, check_count = 0, idx, ones, rises;
	// Clock of 50 ns period.
	always #25 mclk = ~mclk;
	bus_ctrl_model bus_ctrl_model_i (.mclk(mclk), .addr_ack(addr_ack), .data_ack(data_ack), .bus_byte(bus_byte));
	group_blink_and_pattern_gate #(.TICK_LENGTH(TL)) group_blink_and_pattern_gate_i (.mclk(mclk), .resetn(resetn),
		.ce(ce), .addr_ack(addr_ack), .data_ack(data_ack), .bus_byte(bus_byte), .rd_data(rd_data),
		.group_mode_selector(gms), .group_duty_code(duty), .dim_pwm(dim), .output_drive_select(drv),
		.indiv_pwm(pw), .oe_n(oe_n), .led_on(led_on), .blink_period_code(bpc), .pattern_index_field(pif));
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Reference pattern table and output gating.
	function automatic logic [23:0] pat(input int i);
		for (int c = 0; c < 24; c++)
			pat[c] = (i == 0) || (i == 2 && c % 2 == 1) || (i == 3 && c % 2 == 0)
				|| (i >= 4 && i <= 6 && c % 3 == 6 - i) || (i >= 7 && i <= 27 && c == i - 7);
	endfunction
	function automatic logic [23:0] want(input int i);
		for (int c = 0; c < 24; c++)
			want[c] = drv[2*c+1] ? (pw[c] & (drv[2*c] ? dim : 1'b1)) : drv[2*c];
		want = oe_n ? '0 : want & pat(i);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_ctrl_model_i.strobe(1'b1, 1'b0, a);
		bus_ctrl_model_i.strobe(1'b0, 1'b1, d);
	endtask
	task automatic idle(input int n);
		repeat (n) bus_ctrl_model_i.strobe(1'b0, 1'b0, 8'h00);
	endtask
	// Counts on cycles and rising edges of one group-driven channel over whole periods.
	task automatic blink(input logic [7:0] code, input logic [7:0] dut, input int n);
		gms = 1'b0;
		wr(GROUP_BLINK_PERIOD_ADDR, code);
		// Two dimming cycles load the new code as the active one before blinking starts.
		idle(2);
		duty = dut;
		gms = 1'b1;
		idle(4);
		ones = 0;
		rises = 0;
		prev = led_on[0];
		repeat (n * (code + 1) * 256 * TL) begin
			@(negedge mclk);
			ones += int'(led_on[0]);
			rises += int'(led_on[0] & ~prev);
			prev = led_on[0];
		end
		check(48'(ones), 48'(n * (code + 1) * TL * dut));
		check(48'(rises), 48'(n));
		$display("test blink done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence.
	initial begin
		void'($urandom(32'h9109f2ed));
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		check(bpc, GROUP_BLINK_PERIOD_RST);
		check(pif, OUTPUT_PATTERN_INDEX_RST);
		check(rd_data, UNMAPPED_READ);
		check(led_on, '0);
		oe_n = 1'b0;
		bus_ctrl_model_i.strobe(1'b1, 1'b0, OUTPUT_PATTERN_INDEX_ADDR);
		for (int i = 0; i < 30; i++) begin
			bus_ctrl_model_i.strobe(1'b0, 1'b1, 8'(i));
			if (i > 1) begin
				check(pif, 8'(i - 1));
				check(led_on, want(i - 2));
			end
		end
		idle(2);
		check(rd_data, 8'h1D);
		wr(OUTPUT_PATTERN_INDEX_ADDR, PATTERN_ALL_ON);
		idle(2);
		check(led_on, want(0));
		oe_n = 1'b1;
		idle(1);
		check(led_on, '0);
		$display("test sweep done");
		for (int k = 0; k < 24; k++) begin
			per = 8'($urandom());
			idx = $urandom() % 32;
			wr(GROUP_BLINK_PERIOD_ADDR, per);
			wr(OUTPUT_PATTERN_INDEX_ADDR, 8'(idx));
			drv = {$urandom(), 16'($urandom())};
			pw = 24'($urandom());
			dim = 1'($urandom());
			oe_n = ($urandom() % 4) == 0;
			e = want(idx);
			idle(2);
			check(led_on, e);
			check(bpc, per);
		end
		// Read back the period register through the pointer.
		bus_ctrl_model_i.strobe(1'b1, 1'b0, GROUP_BLINK_PERIOD_ADDR);
		idle(2);
		check(rd_data, per);
		// With the clock enable low every strobe is ignored and all state holds.
		ce = 1'b0;
		e = led_on;
		wr(OUTPUT_PATTERN_INDEX_ADDR, ~per);
		idle(2);
		check(bpc, per);
		check(pif, 8'(idx));
		check(rd_data, per);
		check(led_on, e);
		ce = 1'b1;
		wr(8'h05, 8'h55);
		idle(3);
		check(rd_data, UNMAPPED_READ);
		check(bpc, per);
		$display("test random done");
		drv = {24{DRIVE_GROUP}};
		pw = '1;
		oe_n = 1'b0;
		wr(OUTPUT_PATTERN_INDEX_ADDR, PATTERN_ALL_ON);
		blink(8'h01, 8'h80, 2);
		blink(8'h00, 8'h40, 4);
		summarize();
	end
	// Watchdog.
	initial begin
		#1_000_000;
		fail_count++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		summarize();
	end
endmodule // tb_group_blink_and_pattern_gate
`default_nettype wire
